// *** inc/token_capture_defines.vh ***
// constants for the token capture block: register map, fields, symbols, states
// assumes a byte-wide ring symbol stream with a per-bit code violation mask
`ifndef TOKEN_CAPTURE_DEFINES_VH
`define TOKEN_CAPTURE_DEFINES_VH

// ==========================================================================
// register map (byte addresses)
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_COUNT 4'h8

// ==========================================================================
// control register fields
`define CTRL_EN_BIT 0
`define CTRL_AP_LSB 4
`define CTRL_AP_MSB 6
`define CTRL_RESET 32'h0000_0000

// status register fields
`define STAT_STATE_LSB 0
`define STAT_STATE_MSB 3
`define STAT_FALSE_BIT 8
`define STAT_PR_LSB 12
`define STAT_PR_MSB 14

// ==========================================================================
// access control byte layout
`define AC_PI_MSB 7
`define AC_PI_LSB 5
`define AC_TI_BIT 4
`define AC_MC_BIT 3
`define AC_PR_MSB 2
`define AC_PR_LSB 0

// ==========================================================================
// delimiter symbols: data bits and code violation mask
`define SD_DATA 8'h48
`define SD_CV 8'hd8
`define ED_DATA 8'h6c
`define ED_CV 8'hd8
`define ED_CMP_MASK 8'hfc
`define NO_CV 8'h00

// ==========================================================================
// transmit token control states
`define ST_IDLE 4'h0
`define ST_AC 4'h1
`define ST_CHK 4'h2
`define ST_SEND 4'h3
`define ST_EDO 4'h4
`define ST_TSD 4'h5
`define ST_TAC 4'h6
`define ST_TED 4'h7
`define ST_ABORT 4'h8

`endif

// *** core/axil_regs_port.v ***
// axi4-lite slave front end: handshakes one write and one read at a time
// assumes the parent supplies rd_word combinationally from rd_addr
`timescale 1ns/10ps
module axil_regs_port
(
    input wire aclk,
    input wire aresetn,
    input wire [3:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg bvalid,
    output wire [1:0] bresp,
    input wire bready,
    input wire [3:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg rvalid,
    output reg [31:0] rdata,
    output wire [1:0] rresp,
    input wire rready,
    output reg wr_en,
    output reg [3:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    output reg [3:0] rd_addr,
    input wire [31:0] rd_word
);

reg aw_full_q;
reg w_full_q;
reg rd_pend_q;

assign bresp = 2'h0;
assign rresp = 2'h0;

// ==========================================================================
// write channel
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        wr_en <= 1'b0;
        wr_addr <= 4'h0;
        wr_data <= 32'h0000_0000;
        wr_strb <= 4'h0;
    end
    else
    begin
        wr_en <= 1'b0;
        if (awvalid && awready)
        begin
            wr_addr <= awaddr;
            aw_full_q <= 1'b1;
            awready <= 1'b0;
        end
        if (wvalid && wready)
        begin
            wr_data <= wdata;
            wr_strb <= wstrb;
            w_full_q <= 1'b1;
            wready <= 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid)
        begin
            wr_en <= 1'b1;
            bvalid <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
        end
        if (bvalid && bready)
        begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
        end
    end
end

// ==========================================================================
// read channel
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        arready <= 1'b1;
        rvalid <= 1'b0;
        rdata <= 32'h0000_0000;
        rd_addr <= 4'h0;
        rd_pend_q <= 1'b0;
    end
    else
    begin
        if (arvalid && arready)
        begin
            rd_addr <= araddr;
            arready <= 1'b0;
            rd_pend_q <= 1'b1;
        end
        if (rd_pend_q)
        begin
            rdata <= rd_word;
            rvalid <= 1'b1;
            rd_pend_q <= 1'b0;
        end
        if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
end

endmodule

// *** core/token_capture.v ***
// transmit token control: captures a token for a queued frame on a byte ring stream
// assumes ring bytes and queue bytes come from logic on aclk, rx_valid at most every 2nd cycle
//
// Behaviour
// - frame queued: watch stream for starting delimiter
// - violated priority indicator: ignore, await next delimiter
// - indicator above access priority: reserve, repeat
// - indicator not above priority: send token bit one
// - token bit one: reserve only, no transmit
// - token bit zero: monitor bit zero, send frame
// - byte after access byte not end: abort
// - reserve only if priority exceeds reservation
// - eight priority levels, zero lowest, seven highest
// - new token issued: enable priority stacking logic
`timescale 1ns/10ps
`include "token_capture_defines.vh"
module token_capture
(
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire [7:0] rx_cv,
    output reg tx_valid,
    output reg [7:0] tx_byte,
    output reg [7:0] tx_cv,
    input wire fr_valid,
    input wire [7:0] fr_data,
    input wire fr_last,
    output reg fr_take,
    output reg prio_enable
);

// ==========================================================================
// register access
wire wr_en;
wire [3:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire [3:0] rd_addr;
reg [31:0] rd_word;

reg en_q;
reg [2:0] ap_q;
reg false_q;
reg [15:0] count_q;
reg [3:0] state_q;
reg [2:0] pi_q;
reg [2:0] pr_q;
reg [2:0] pr_last_q;

axil_regs_port u_port
(
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bvalid(s_axi_bvalid),
    .bresp(s_axi_bresp),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rvalid(s_axi_rvalid),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_word(rd_word)
);

always @*
begin
    rd_word = 32'h0000_0000;
    case (rd_addr)
        `OFS_CTRL:
        begin
            rd_word[`CTRL_EN_BIT] = en_q;
            rd_word[`CTRL_AP_MSB:`CTRL_AP_LSB] = ap_q;
        end
        `OFS_STATUS:
        begin
            rd_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_q;
            rd_word[`STAT_FALSE_BIT] = false_q;
            rd_word[`STAT_PR_MSB:`STAT_PR_LSB] = pr_last_q;
        end
        `OFS_COUNT:
        begin
            rd_word[15:0] = count_q;
        end
        default:
        begin
            rd_word = 32'h0000_0000;
        end
    endcase
end

wire ctrl_wr = wr_en && (wr_addr == `OFS_CTRL) && wr_strb[0];
wire false_clr = wr_en && (wr_addr == `OFS_STATUS) && wr_strb[1] && wr_data[`STAT_FALSE_BIT];

// ==========================================================================
// received byte decode
wire [2:0] rx_pi = rx_byte[`AC_PI_MSB:`AC_PI_LSB];
wire rx_ti = rx_byte[`AC_TI_BIT];
wire [2:0] rx_pr = rx_byte[`AC_PR_MSB:`AC_PR_LSB];
wire pi_bad = |rx_cv[`AC_PI_MSB:`AC_PI_LSB];
wire is_sd = (rx_byte == `SD_DATA) && (rx_cv == `SD_CV);
wire is_ed = ((rx_byte & `ED_CMP_MASK) == `ED_DATA) && (rx_cv == `ED_CV);
wire queued = en_q && fr_valid;
// reservation raised only by a strictly higher access priority
wire [2:0] pr_upd = (ap_q > rx_pr) ? ap_q : rx_pr;
wire [7:0] ac_resv = {rx_byte[7:3], pr_upd};
wire [7:0] ac_grab = {rx_pi, 1'b1, 1'b0, 3'h0};
wire [7:0] ac_token = {pi_q, 1'b0, 1'b0, pr_q};

// ==========================================================================
// transmit token control
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        state_q <= `ST_IDLE;
        tx_valid <= 1'b0;
        tx_byte <= 8'h00;
        tx_cv <= 8'h00;
        fr_take <= 1'b0;
        prio_enable <= 1'b0;
        pi_q <= 3'h0;
        pr_q <= 3'h0;
        pr_last_q <= 3'h0;
        count_q <= 16'h0000;
        false_q <= 1'b0;
        en_q <= 1'b0;
        ap_q <= 3'h0;
    end
    else
    begin
        tx_valid <= rx_valid;
        fr_take <= 1'b0;
        prio_enable <= 1'b0;
        if (ctrl_wr)
        begin
            en_q <= wr_data[`CTRL_EN_BIT];
            ap_q <= wr_data[`CTRL_AP_MSB:`CTRL_AP_LSB];
        end
        if (false_clr)
        begin
            false_q <= 1'b0;
        end
        if (rx_valid)
        begin
            tx_byte <= rx_byte;
            tx_cv <= rx_cv;
            case (state_q)
                `ST_IDLE:
                begin
                    if (queued && is_sd)
                    begin
                        state_q <= `ST_AC;
                    end
                end
                `ST_AC:
                begin
                    pr_last_q <= rx_pr;
                    if (pi_bad)
                    begin
                        state_q <= `ST_IDLE;
                    end
                    else if (rx_pi > ap_q)
                    begin
                        tx_byte <= ac_resv;
                        state_q <= `ST_IDLE;
                    end
                    else if (rx_ti)
                    begin
                        tx_byte <= ac_resv;
                        state_q <= `ST_IDLE;
                    end
                    else
                    begin
                        tx_byte <= ac_grab;
                        pi_q <= rx_pi;
                        pr_q <= rx_pr;
                        state_q <= `ST_CHK;
                    end
                end
                `ST_CHK:
                begin
                    if (is_ed)
                    begin
                        tx_byte <= fr_data;
                        tx_cv <= `NO_CV;
                        fr_take <= 1'b1;
                        count_q <= count_q + 16'h0001;
                        state_q <= fr_last ? `ST_EDO : `ST_SEND;
                    end
                    else
                    begin
                        tx_byte <= `SD_DATA;
                        tx_cv <= `SD_CV;
                        false_q <= 1'b1;
                        state_q <= `ST_ABORT;
                    end
                end
                `ST_SEND:
                begin
                    tx_byte <= fr_data;
                    tx_cv <= `NO_CV;
                    fr_take <= 1'b1;
                    if (fr_last)
                    begin
                        state_q <= `ST_EDO;
                    end
                end
                `ST_EDO:
                begin
                    tx_byte <= `ED_DATA;
                    tx_cv <= `ED_CV;
                    state_q <= `ST_TSD;
                end
                `ST_TSD:
                begin
                    tx_byte <= `SD_DATA;
                    tx_cv <= `SD_CV;
                    state_q <= `ST_TAC;
                end
                `ST_TAC:
                begin
                    tx_byte <= ac_token;
                    tx_cv <= `NO_CV;
                    state_q <= `ST_TED;
                end
                `ST_TED:
                begin
                    tx_byte <= `ED_DATA;
                    tx_cv <= `ED_CV;
                    prio_enable <= 1'b1;
                    state_q <= `ST_IDLE;
                end
                `ST_ABORT:
                begin
                    tx_byte <= `ED_DATA;
                    tx_cv <= `ED_CV;
                    state_q <= `ST_IDLE;
                end
                default:
                begin
                    state_q <= `ST_IDLE;
                end
            endcase
        end
    end
end

endmodule

// *** sim/token_capture_assertions.sv ***
// checker for the token capture block: ring timing, queue take, register bus
// assumes it is bound to token_capture and sees only its ports
`timescale 1ns/10ps
`include "token_capture_defines.vh"
module token_capture_assertions
(
    input wire aclk,
    input wire aresetn,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] s_axi_rresp,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire [7:0] rx_cv,
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire [7:0] tx_cv,
    input wire fr_valid,
    input wire fr_take,
    input wire prio_enable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ======================================================================
    // sequences
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // byte arriving after a long stretch with nothing queued
    sequence quiet_byte;
        !fr_valid [*8] ##0 rx_valid;
    endsequence

    // ======================================================================
    // register bus
    bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    bvalid_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stayed after handshake");
    read_latency_a: assert property (ar_take |-> ##2 s_axi_rvalid)
        else $error("read data late");
    rvalid_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data stayed after handshake");
    rresp_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");

    // ======================================================================
    // ring and queue
    ring_delay_a: assert property (rx_valid |=> tx_valid)
        else $error("ring byte not forwarded next cycle");
    tx_pulse_a: assert property (tx_valid |=> !tx_valid)
        else $error("tx_valid longer than one cycle");
    plain_repeat_a: assert property (quiet_byte |=>
        tx_byte == $past(rx_byte) && tx_cv == $past(rx_cv))
        else $error("idle ring byte altered");
    take_cause_a: assert property (fr_take |-> $past(rx_valid) && !$past(fr_take))
        else $error("queue take without ring byte");
    prio_on_ed_a: assert property (prio_enable |->
        tx_valid && tx_byte == `ED_DATA && tx_cv == `ED_CV)
        else $error("stacking enable away from ending delimiter");
endmodule

bind token_capture token_capture_assertions chk (.*);

// *** sim/ring_station_model.sv ***
// upstream ring station: hands one ring byte per call to the block
// assumes aclk from the bench; bytes spaced two cycles apart
`timescale 1ns/10ps
module ring_station_model
(
    input wire aclk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic [7:0] rx_cv
);
    initial
    begin
        rx_valid = 1'h0;
        rx_byte = 8'h00;
        rx_cv = 8'h00;
    end

    // one pulse, then scrambled lines while idle
    task put(input logic [16:0] w);
        @(posedge aclk);
        rx_valid <= 1'h1;
        rx_byte <= w[7:0];
        rx_cv <= w[15:8];
        @(posedge aclk);
        rx_valid <= 1'h0;
        rx_byte <= ~w[7:0];
        rx_cv <= ~w[15:8];
    endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the token capture block
// assumes ring_station_model upstream and a three byte frame in the queue
`timescale 1ns/10ps
module testbench;
    localparam logic [16:0] SD = 17'h0d848;
    localparam logic [16:0] ED = 17'h0d86c;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire rx_valid, tx_valid, fr_take, prio_enable;
    wire [7:0] rx_byte, rx_cv, tx_byte, tx_cv;
    logic fr_valid = 1'h0, fr_last = 1'h0;
    logic [7:0] fr_data = 8'ha1;
    int fi = 0, fails = 0, checks = 0;
    logic [16:0] rx_q[$], ex_q[$], tx_q[$];

    always #20 aclk = ~aclk;
    token_capture dut (.*);
    ring_station_model ring (.*);

    // ======================================================================
    // monitor and frame queue a1 a2 a3
    always @(posedge aclk)
        if (tx_valid)
            tx_q.push_back({prio_enable, tx_cv, tx_byte});
    always @(posedge aclk)
        if (fr_take)
        begin
            fi <= fi + 1;
            fr_data <= 8'ha2 + fi[7:0];
            fr_last <= fi == 1;
            fr_valid <= fi < 2;
        end

    // ======================================================================
    // bus tasks
    task axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task axr(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        rd = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h, want %h", $time, g, e);
        end
    endtask
    // sends rx_q upstream, compares forwarded stream with ex_q
    task go(input string name);
        tx_q = {};
        foreach (rx_q[i])
            ring.put(rx_q[i]);
        repeat (4) @(posedge aclk);
        ck(tx_q.size(), ex_q.size());
        foreach (ex_q[i])
            ck(tx_q[i], ex_q[i]);
        $display("test %s done", name);
    endtask

    // ======================================================================
    // scenarios
    task t_repeat;
        rx_q = '{SD, 17'h0002d, ED, 17'h00055, 17'h0e0aa};
        ex_q = rx_q;
        go("repeat");
    endtask
    task t_regs;
        axr(4'h0);
        ck(rd, 32'h0);
        axr(4'h8);
        ck(rd, 32'h0);
        axr(4'hc);
        ck(rd, 32'h0);
        axw(4'h0, 32'h21, 4'hf);
        axr(4'h0);
        ck(rd, 32'h21);
        fr_valid <= 1'h1;
        $display("test regs done");
    endtask
    task t_reserve;
        rx_q = '{SD, 17'h00060, ED, SD, 17'h000a2, ED};
        ex_q = '{SD, 17'h00062, ED, SD, 17'h000a2, ED};
        go("reserve");
        axr(4'h4);
        ck(rd, 32'h0000_2000);
    endtask
    task t_frame;
        rx_q = '{SD, 17'h00010, 17'h00040, ED};
        ex_q = '{SD, 17'h00012, 17'h00040, ED};
        go("frame");
    endtask
    task t_pviol;
        rx_q = '{SD, 17'h0e000, ED};
        ex_q = rx_q;
        go("violation");
    endtask
    task t_false;
        rx_q = '{SD, 17'h00000, 17'h00055, 17'h00000};
        ex_q = '{SD, 17'h00010, SD, ED};
        go("false token");
        axr(4'h4);
        ck(rd[8], 1'h1);
        axw(4'h4, 32'h100, 4'h2);
        axr(4'h4);
        ck(rd[8], 1'h0);
        axr(4'h8);
        ck(rd, 32'h0);
    endtask
    task t_capture;
        rx_q = '{SD, 17'h0002d, ED, 17'h0, 17'h0, 17'h0, 17'h0, 17'h0, 17'h0};
        ex_q = '{SD, 17'h00030, 17'h000a1, 17'h000a2, 17'h000a3, ED, SD, 17'h00025,
            17'h1d86c};
        go("capture");
        axr(4'h8);
        ck(rd, 32'h1);
        ck(fi, 3);
    endtask

    // ======================================================================
    // sequence, watchdog, verdict
    task close_out;
        $display("checks %0d, fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_repeat;
        t_regs;
        t_reserve;
        t_frame;
        t_pviol;
        t_false;
        t_capture;
        close_out;
    end
    initial
    begin
        repeat (3000) @(posedge aclk);
        fails++;
        close_out;
    end
endmodule
